// File: nvac_chk.sv
// timing checks on the ports of the nonvolatile array controller
// assumes it is bound into nvac_top with the same write length
`timescale 1ns/1ps
module nvac_chk
  import nvac_pkg::*;
#(parameter int WRITE_CYCLES = 8) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events and programmer port
  input wire logic        master_clear_reset,
  input wire logic        watchdog_reset_source,
  input wire logic        code_protect,
  input wire logic        prog_rd,
  input wire logic [7:0]  prog_rdata,
  input wire logic        prog_denied,
  input wire logic        write_busy
);
  logic [31:0] busy_cnt_q;
  wire         ctl_rd = pready && !pwrite && paddr[9:2] == NVAC_OFF_CTRL;
  wire         ulk_rd = pready && !pwrite && paddr[9:2] == NVAC_OFF_UNLOCK;
  wire         wgo = psel && penable && pwrite && paddr[9:2] == NVAC_OFF_CTRL
                     && pwdata[NVAC_BIT_WR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= write_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_ctrl_top: assert property (ctl_rd |-> prdata[31:5] == 27'h0)
    else $error("control top bits set");
  a_unlock_empty: assert property (ulk_rd |-> prdata == 32'h0)
    else $error("unlock port reads data");
  a_busy_bound: assert property (busy_cnt_q <= WRITE_CYCLES + 1)
    else $error("write runs too long");
  a_abort_stop: assert property ((master_clear_reset || watchdog_reset_source) && write_busy
    |-> ##[1:2] !write_busy) else $error("write not aborted");
  a_prot_deny: assert property (prog_rd && code_protect |=> prog_denied && prog_rdata == 8'h00)
    else $error("programmer not blocked");
  a_open_allow: assert property (prog_rd && !code_protect |=> !prog_denied)
    else $error("programmer blocked");
  a_start_go: assert property ($rose(write_busy) |-> $past(wgo) || $past(wgo, 2) || $past(wgo, 3))
    else $error("write started without go");
  a_rd_clear: assert property (ctl_rd |-> !prdata[NVAC_BIT_RD])
    else $error("read go seen set");
  a_busy_len: assert property ($fell(write_busy) && !$past(master_clear_reset) &&
    !$past(watchdog_reset_source) |-> busy_cnt_q == WRITE_CYCLES)
    else $error("write length wrong");
endmodule : nvac_chk
bind nvac_top nvac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clear_reset(master_clear_reset),
  .watchdog_reset_source(watchdog_reset_source), .code_protect(code_protect),
  .prog_rd(prog_rd), .prog_rdata(prog_rdata), .prog_denied(prog_denied),
  .write_busy(write_busy));

// File: nvac_cpu.sv
// cpu side model: issues apb register accesses on request
// assumes one clock, requests held until pready is seen high
`timescale 1ns/1ps
module nvac_cpu (
  // apb
  input wire logic        pclk,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [31:0]     paddr,
  output logic [31:0]     pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] off, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, off, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not look valid
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : nvac_cpu

// File: nvac_pkg.sv
// package for the nonvolatile data array access controller
// assumes an apb slave with 32-bit data, one aligned word per register
package nvac_pkg;

  // ***************************************************************
  // register indices: the byte address is four times the index
  // ***************************************************************
  localparam logic [7:0] NVAC_OFF_DATA   = 8'h08;
  localparam logic [7:0] NVAC_OFF_ADDR   = 8'h09;
  localparam logic [7:0] NVAC_OFF_CTRL   = 8'h88;
  localparam logic [7:0] NVAC_OFF_UNLOCK = 8'h89;
  localparam logic [7:0] NVAC_OFF_STRAP  = 8'h8A;

  // ***************************************************************
  // control register fields
  // ***************************************************************
  localparam int NVAC_BIT_RD    = 0;
  localparam int NVAC_BIT_WR    = 1;
  localparam int NVAC_BIT_WRITE_PERMIT  = 2;
  localparam int NVAC_BIT_ABORT = 3;
  localparam int NVAC_BIT_DONE  = 4;

  // ***************************************************************
  // unlock keys and array geometry
  // ***************************************************************
  localparam logic [7:0] NVAC_KEY1      = 8'h55;
  localparam logic [7:0] NVAC_KEY2      = 8'hAA;
  localparam int         NVAC_DEPTH     = 64;
  localparam int         NVAC_AW        = 6;
  localparam logic [7:0] NVAC_BYTE_ZERO = 8'h00;
  localparam logic [7:0] NVAC_ERASED    = 8'hFF;

  // ***************************************************************
  // write timing
  // ***************************************************************
  localparam int NVAC_CLK_MHZ     = 20;
  localparam int NVAC_WRITE_US    = 4000;
  localparam int NVAC_WRITE_CYC   = NVAC_WRITE_US * NVAC_CLK_MHZ;
  localparam int NVAC_ERASE_SHARE = 2;

  typedef enum logic [2:0] {
    NVAC_IDLE  = 3'b001,
    NVAC_ERASE = 3'b010,
    NVAC_PROG  = 3'b100
  } nvac_state_t;

  typedef enum logic [2:0] {
    NVAC_UL_NONE = 3'b001,
    NVAC_UL_KEY1 = 3'b010,
    NVAC_UL_OPEN = 3'b100
  } nvac_unlock_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] off;
    logic [7:0] wdata;
  } nvac_req_t;

endpackage : nvac_pkg

// File: nvac_top.sv
// access controller for a 64-byte nonvolatile data array behind apb
// assumes pclk at 20 MHz; clear and watchdog resets arrive as sync pulses
//
// Notes on behaviour
// - array of 64 bytes, locations 0h to 3Fh.
// - 8-bit data register and separate address register select the location.
// - every byte write erases the location, then programs the new byte.
// - write duration set by an internal timer, not software.
// - code protection blocks programmer access; cpu access still works.
// - unlock port has no storage and reads zero.
// - abort flag bit 3 set when clear or watchdog reset cuts a write.
// - write permit bit 2 enables writes; resets to 0.
// - write go bit 1 starts a write; hardware clears; writing 0 ignored.
// - read go bit 0 starts one-cycle read; hardware clears it.
// - read byte lands in data register the next cycle.
// - data register holds until next read or software write.
// - control bits 7 to 5 read as zero.
// - write starts only after 55h, AAh to unlock port, then write go.
// - write go cannot be set unless write permit is already set.
// - clearing write permit mid-write leaves that write running.
// - on completion clear write go and set done flag; software clears it.
`timescale 1ns/1ps
module nvac_top
  import nvac_pkg::*;
#(
  parameter int WRITE_CYCLES = NVAC_WRITE_CYC,
  parameter int DEPTH        = NVAC_DEPTH
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device reset events and protection
  input  wire logic        master_clear_reset,
  input  wire logic        watchdog_reset_source,
  input  wire logic        code_protect,
  // external programmer port
  input  wire logic        prog_rd,
  input  wire logic [5:0]  prog_addr,
  output logic      [7:0]  prog_rdata,
  output logic             prog_denied,
  output logic             write_busy
);

  // refuse parameter values that the array and the timer cannot serve
  if (DEPTH != NVAC_DEPTH || WRITE_CYCLES < NVAC_ERASE_SHARE) begin : g_bad_param
    $error("nvac_top: unsupported depth or write time");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0]   mem_q [DEPTH];
  logic [7:0]   data_q, addr_q;
  logic         rd_q, wr_q, write_permit_q, abort_q, done_q;
  nvac_state_t  st_q, st_d;
  nvac_unlock_t ul_q, ul_d;
  logic [31:0]  tmr_q, tmr_d;
  logic [31:0]  prdata_d;
  logic         pready_q;
  logic         cut;

  function automatic logic [NVAC_AW-1:0] loc(input logic [7:0] a);
    return a[NVAC_AW-1:0];
  endfunction : loc

  // ***************************************************************
  // bus decode
  // ***************************************************************
  nvac_req_t req;
  assign req.wr    = pwrite;
  assign req.off   = paddr[9:2];
  assign req.wdata = pwdata[7:0];

  wire acc      = psel & penable & ~pready_q;
  wire wr_acc   = acc & req.wr;
  wire mapped   = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0) &&
                  (req.off == NVAC_OFF_DATA || req.off == NVAC_OFF_ADDR ||
                   req.off == NVAC_OFF_CTRL || req.off == NVAC_OFF_UNLOCK ||
                   req.off == NVAC_OFF_STRAP);
  wire w_data   = wr_acc && req.off == NVAC_OFF_DATA;
  wire w_addr   = wr_acc && req.off == NVAC_OFF_ADDR;
  wire w_ctrl   = wr_acc && req.off == NVAC_OFF_CTRL;
  wire w_unlock = wr_acc && req.off == NVAC_OFF_UNLOCK;
  wire busy     = st_q != NVAC_IDLE;
  wire rd_go    = w_ctrl && req.wdata[NVAC_BIT_RD] && !busy;
  wire wr_go    = w_ctrl && req.wdata[NVAC_BIT_WR] && !busy && write_permit_q
                  && ul_q == NVAC_UL_OPEN;
  wire finish   = st_q == NVAC_PROG && tmr_q == 32'h00000000;
  assign cut    = master_clear_reset | watchdog_reset_source;

  wire [7:0] ctrl_rd = {3'b000, done_q, abort_q, write_permit_q, wr_q, rd_q};

  // ***************************************************************
  // unlock sequencer: any other write to the port or control breaks it
  // ***************************************************************
  always_comb begin
    ul_d = ul_q;
    if (w_unlock) begin
      if (req.wdata == NVAC_KEY1) begin
        ul_d = NVAC_UL_KEY1;
      end else if (req.wdata == NVAC_KEY2 && ul_q == NVAC_UL_KEY1) begin
        ul_d = NVAC_UL_OPEN;
      end else begin
        ul_d = NVAC_UL_NONE;
      end
    end else if (w_ctrl) begin
      ul_d = NVAC_UL_NONE;
    end
  end

  // ***************************************************************
  // self-timed erase then program
  // ***************************************************************
  always_comb begin
    st_d  = st_q;
    tmr_d = tmr_q;
    case (st_q)
      NVAC_IDLE: begin
        if (wr_go) begin
          st_d  = NVAC_ERASE;
          tmr_d = 32'(WRITE_CYCLES / NVAC_ERASE_SHARE - 1);
        end
      end
      NVAC_ERASE: begin
        if (tmr_q == 32'h00000000) begin
          st_d  = NVAC_PROG;
          tmr_d = 32'(WRITE_CYCLES - WRITE_CYCLES / NVAC_ERASE_SHARE - 1);
        end else begin
          tmr_d = tmr_q - 32'h00000001;
        end
      end
      NVAC_PROG: begin
        if (tmr_q == 32'h00000000) begin
          st_d = NVAC_IDLE;
        end else begin
          tmr_d = tmr_q - 32'h00000001;
        end
      end
      default: st_d = NVAC_IDLE;
    endcase
    if (cut) begin
      st_d = NVAC_IDLE;
    end
  end

  // ***************************************************************
  // read mux
  // ***************************************************************
  always_comb begin
    prdata_d = 32'h00000000;
    case (req.off)
      NVAC_OFF_DATA:  prdata_d = {24'h000000, data_q};
      NVAC_OFF_ADDR:  prdata_d = {24'h000000, addr_q};
      NVAC_OFF_CTRL:  prdata_d = {24'h000000, ctrl_rd};
      NVAC_OFF_STRAP: prdata_d = {31'h00000000, code_protect};
      default:        prdata_d = 32'h00000000;
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= NVAC_IDLE;
      ul_q     <= NVAC_UL_NONE;
      tmr_q    <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
    end else begin
      st_q     <= st_d;
      ul_q     <= ul_d;
      tmr_q    <= tmr_d;
      pready_q <= acc;
      pslverr  <= acc & ~mapped;
      prdata   <= (acc && !req.wr) ? prdata_d : 32'h00000000;
    end
  end
  assign pready = pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= NVAC_BYTE_ZERO;
      addr_q <= NVAC_BYTE_ZERO;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      write_permit_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      rd_q <= rd_go;
      if (rd_go) begin
        data_q <= mem_q[loc(addr_q)];
      end else if (w_data) begin
        data_q <= req.wdata;
      end
      if (w_addr) begin
        addr_q <= req.wdata;
      end
      if (w_ctrl) begin
        write_permit_q <= req.wdata[NVAC_BIT_WRITE_PERMIT];
      end
      // a reset pulse in the start cycle cuts that write too, so wr never sticks
      if (cut && (busy || wr_go)) begin
        wr_q    <= 1'b0;
        abort_q <= 1'b1;
      end else if (finish) begin
        wr_q    <= 1'b0;
        abort_q <= 1'b0;
      end else begin
        if (wr_go) begin
          wr_q <= 1'b1;
        end
        if (w_ctrl) begin
          abort_q <= req.wdata[NVAC_BIT_ABORT];
        end
      end
      if (finish && !cut) begin
        done_q <= 1'b1;
      end else if (w_ctrl) begin
        done_q <= req.wdata[NVAC_BIT_DONE];
      end
    end
  end

  // ***************************************************************
  // array and programmer port
  // ***************************************************************
  always_ff @(posedge pclk) begin
    if (st_q == NVAC_ERASE && tmr_q == 32'h00000000 && !cut) begin
      mem_q[loc(addr_q)] <= NVAC_ERASED;
    end else if (finish && !cut) begin
      mem_q[loc(addr_q)] <= data_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rdata  <= NVAC_BYTE_ZERO;
      prog_denied <= 1'b0;
      write_busy  <= 1'b0;
    end else begin
      write_busy  <= st_d != NVAC_IDLE;
      prog_denied <= prog_rd & code_protect;
      if (prog_rd) begin
        prog_rdata <= code_protect ? NVAC_BYTE_ZERO : mem_q[prog_addr];
      end
    end
  end

endmodule : nvac_top

// File: nvac_top_bench.sv
// self-checking bench for the nonvolatile array controller
// assumes nvac_cpu as bus master and a shortened write length
`timescale 1ns/1ps
module nvac_top_bench
  import nvac_pkg::*;
;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} nvac_row_t;
  logic pclk = 1'b0, presetn = 1'b0, mcr = 1'b0, wdt = 1'b0, cp = 1'b0, prd = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pden, busy, e;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [7:0] prdat;
  int errors = 0, check_count = 0;
  nvac_row_t rows [11] = '{'{0, NVAC_OFF_CTRL, 0, 0, 0}, '{0, NVAC_OFF_DATA, 0, 0, 0},
    '{1, NVAC_OFF_DATA, 8'h5A, 0, 0}, '{0, NVAC_OFF_DATA, 0, 8'h5A, 0},
    '{0, NVAC_OFF_UNLOCK, 0, 0, 0}, '{1, NVAC_OFF_UNLOCK, 8'h55, 0, 0},
    '{1, NVAC_OFF_CTRL, 8'hE4, 0, 0}, '{0, NVAC_OFF_CTRL, 0, 8'h04, 0},
    '{1, NVAC_OFF_CTRL, 8'h02, 0, 0}, '{0, NVAC_OFF_CTRL, 0, 0, 0}, '{0, 8'h40, 0, 0, 1}};
  always #25 pclk = ~pclk;
  nvac_cpu u_cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  nvac_top #(.WRITE_CYCLES(40)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clear_reset(mcr), .watchdog_reset_source(wdt),
    .code_protect(cp), .prog_rd(prd), .prog_addr(6'h05), .prog_rdata(prdat),
    .prog_denied(pden), .write_busy(busy));
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task w(input logic [7:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, v, e);
  endtask : w
  task rc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    u_cpu.xfer(1'b0, a, 8'h00, v, e);
    chk("read", {v[31:8], v[7:0] & m}, {24'h0, x});
  endtask : rc
  task go(input logic [7:0] k2);
    w(NVAC_OFF_CTRL, 8'h04);
    w(NVAC_OFF_UNLOCK, NVAC_KEY1);
    w(NVAC_OFF_UNLOCK, k2);
    w(NVAC_OFF_CTRL, 8'h06);
  endtask : go
  task idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge pclk);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask : idle
  task prog(input logic c, input logic dn, input logic [7:0] x);
    @(posedge pclk) begin cp <= c; prd <= 1'b1; end
    @(posedge pclk) prd <= 1'b0;
    @(negedge pclk) chk("prog", {23'h0, pden, prdat}, {23'h0, dn, x});
  endtask : prog
  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      u_cpu.xfer(rows[i].w, rows[i].a, rows[i].d, v, e);
      chk("row", {23'h0, e, v[7:0]}, {23'h0, rows[i].e, rows[i].x});
    end
    $display("test rows done");
    w(NVAC_OFF_ADDR, 8'h05);
    w(NVAC_OFF_DATA, 8'hC3);
    go(NVAC_KEY2);
    rc(NVAC_OFF_CTRL, 8'h06);
    w(NVAC_OFF_CTRL, 8'h01);
    rc(NVAC_OFF_CTRL, 8'h02);
    rc(NVAC_OFF_DATA, 8'hC3);
    idle();
    rc(NVAC_OFF_CTRL, 8'h10);
    w(NVAC_OFF_CTRL, 8'h00);
    rc(NVAC_OFF_CTRL, 8'h00);
    $display("test write done");
    @(posedge pclk) cp <= 1'b1;
    w(NVAC_OFF_ADDR, 8'h45);
    w(NVAC_OFF_CTRL, 8'h01);
    rc(NVAC_OFF_CTRL, 8'h00);
    rc(NVAC_OFF_DATA, 8'hC3);
    prog(1'b1, 1'b1, 8'h00);
    prog(1'b0, 1'b0, 8'hC3);
    $display("test read done");
    go(8'h11);
    rc(NVAC_OFF_CTRL, 8'h04);
    w(NVAC_OFF_CTRL, 8'h00);
    w(NVAC_OFF_UNLOCK, NVAC_KEY1);
    w(NVAC_OFF_UNLOCK, NVAC_KEY2);
    w(NVAC_OFF_CTRL, 8'h02);
    rc(NVAC_OFF_CTRL, 8'h00);
    $display("test unlock done");
    for (int k = 0; k < 2; k++) begin
      go(NVAC_KEY2);
      repeat (k * 25) @(posedge pclk);
      @(posedge pclk) begin mcr <= (k == 0); wdt <= (k == 1); end
      @(posedge pclk) begin mcr <= 1'b0; wdt <= 1'b0; end
      idle();
      rc(NVAC_OFF_CTRL, 8'h0C, 8'h0E);
      prog(1'b0, 1'b0, (k == 1) ? 8'hFF : 8'hC3);
    end
    $display("test abort done");
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(NVAC_OFF_CTRL, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule : nvac_top_bench
